// ### logic/sdmu_regs.svh
// Constants of the string and decimal move unit.
// Assumes a byte-wide memory port and a plain register port.
//
// Contract
// (RQ1) Pair stored as 16-byte packed decimal
// (RQ2) Software names an even first register
// (RQ3) Every string operation can be interrupted
// (RQ4) Escape byte is register 0 bits 24:31
// (RQ5) Register 2 nonzero selects translation table
// (RQ6) Escape match sets C, stores nothing
// (RQ7) Stop on escape, full, or exhausted
// (RQ8) Next source address returned in register 1
// (RQ9) Bytes move in ascending address order
// (RQ10) Pad fills destination after source ends
// (RQ11) Destination full first gives V, 0100
// (RQ12) Default pad forms ignore register 0
// (RQ13) Compare stops at first unequal pair
// (RQ14) Shorter compare string extended with pad
// (RQ15) Register 1 gets matched second-operand count
// (RQ16) Compare codes 0000, 0010, 0001
// (RQ17) Pack lengths are one plus field
// (RQ18) Pack zoned to packed, zero fill
// (RQ19) Absolute pack forces positive sign
// (RQ20) Short destination sets V, keeps low digits
// (RQ21) Illegal zoned digit sets C
// (RQ22) Pack runs right to left, overlap exposed
// (RQ23) Sign and digit legality codes
`ifndef SDMU_REGS_SVH
`define SDMU_REGS_SVH
`define SDMU_A_CTRL 8'h00
`define SDMU_A_STAT 8'h04
`define SDMU_A_GR0 8'h08
`define SDMU_A_GR1 8'h0c
`define SDMU_A_GR2 8'h10
`define SDMU_A_ADR1 8'h14
`define SDMU_A_LEN1 8'h18
`define SDMU_A_ADR2 8'h1c
`define SDMU_A_LEN2 8'h20
`define SDMU_A_PHI 8'h24
`define SDMU_A_PLO 8'h28
`define SDMU_CT_OP 2:0
`define SDMU_CT_GO 4
`define SDMU_CT_RES 5
`define SDMU_ST_BUSY 0
`define SDMU_ST_SUSP 1
`define SDMU_ST_CC 7:4
`define SDMU_OP_STORE_BINARY_AS_PACKED 3'h0
`define SDMU_OP_MOVE_TRANSLATED_UNTIL_ESCAPE 3'h1
`define SDMU_OP_MOVE 3'h2
`define SDMU_OP_COPY_WITH_SPACE_PAD 3'h3
`define SDMU_OP_TEXT_COMPARE_WITH_PAD 3'h4
`define SDMU_OP_TEXT_COMPARE_SPACE_PAD 3'h5
`define SDMU_OP_PMV 3'h6
`define SDMU_OP_ZONED_TO_PACKED_COPY_POSITIVE 3'h7
`define SDMU_CC_ZERO 4'h0
`define SDMU_CC_LT 4'h1
`define SDMU_CC_GT 4'h2
`define SDMU_CC_V 4'h4
`define SDMU_CC_C 4'h8
`define SDMU_PAD_SPACE 8'h20
`define SDMU_SGN_PLUS 4'hc
`define SDMU_SGN_MINUS 4'hd
`define SDMU_STORE_BINARY_AS_PACKED_LAST 32'h0000000f
`define SDMU_STORE_BINARY_AS_PACKED_BYTES 32'h00000010
`endif

// ### logic/sdmu_pkg.sv
// Types of the string and decimal move unit.
// Assumes the constants header is compiled alongside.
package sdmu_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_STEP, S_RD_SRC, S_RD_TBL, S_WR_DST, S_RD_OP1, S_RD_OP2, S_CP_CMP, S_PK_RD
  } sdmu_fsm_e;
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
  } sdmu_mreq_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sdmu_bus_s;
  typedef struct packed {
    sdmu_fsm_e fsm;
    logic [2:0] op;
    logic busy;
    logic susp;
    logic done;
    logic [3:0] cc;
    logic [31:0] gr0;
    logic [31:0] gr1;
    logic [31:0] gr2;
    logic [31:0] a1;
    logic [31:0] l1;
    logic [31:0] a2;
    logic [31:0] l2;
    logic [31:0] hi;
    logic [31:0] lo;
    logic [63:0] mag;
    logic [31:0] cnt;
    logic [7:0] arg;
    logic [7:0] cmpb;
    logic [3:0] nib;
    logic half;
    logic sgn_done;
    logic from_src;
    logic neg;
    logic nzero;
    logic ovf;
    logic bad;
    sdmu_mreq_s mem;
    logic [31:0] rdata;
  } sdmu_st_s;
endpackage : sdmu_pkg

// ### logic/sdmu_unit.sv
// String and decimal move unit: registers, sequencer, memory port.
// Assumes a byte memory that answers each request with one ack pulse.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "sdmu_regs.svh"
module sdmu_unit
  import sdmu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire sdmu_bus_s i_bus,
  output logic [31:0] o_rdata,
  input wire logic i_intr,
  output sdmu_mreq_s o_mem,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_rdata,
  output logic o_busy,
  output logic o_susp,
  output logic o_done,
  output logic [3:0] o_cc
);
  sdmu_st_s st_reg;
  sdmu_st_s st_next;
  logic ak;
  logic is_pk;
  logic [7:0] pad;
  logic [7:0] targ;
  logic [63:0] q1;
  logic [63:0] q2;
  logic [63:0] m1;
  logic [63:0] m2;
  logic [3:0] dg;
  logic [3:0] sg;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic sdmu_st_s f_iss(sdmu_st_s s, logic [31:0] a, logic w, logic [7:0] d, sdmu_fsm_e f);
    s.mem.req = 1'b1;
    s.mem.we = w;
    s.mem.addr = a;
    s.mem.wdata = d;
    s.fsm = f;
    return s;
  endfunction : f_iss

  function automatic sdmu_st_s f_fin(sdmu_st_s s, logic [3:0] c);
    s.cc = c;
    s.busy = 1'b0;
    s.done = 1'b1;
    s.fsm = S_IDLE;
    return s;
  endfunction : f_fin

  function automatic logic f_minus(logic [3:0] x);
    return x == 4'hd || x == 4'hb;
  endfunction : f_minus

  function automatic logic f_sgn_ok(logic [3:0] x);
    return f_minus(x) || x == 4'hc || x == 4'ha || x == 4'he || x == 4'hf || x == 4'h3;
  endfunction : f_sgn_ok

  assign ak = st_reg.mem.req & i_mem_ack;
  assign is_pk = st_reg.op == `SDMU_OP_PMV || st_reg.op == `SDMU_OP_ZONED_TO_PACKED_COPY_POSITIVE;
  // Default forms never look at register 0
  assign pad = (st_reg.op == `SDMU_OP_COPY_WITH_SPACE_PAD || st_reg.op == `SDMU_OP_TEXT_COMPARE_SPACE_PAD) ?
    `SDMU_PAD_SPACE : st_reg.gr0[7:0]; // see RQ10 see RQ12 see RQ14
  // Fetched byte as argument: table result or source byte
  assign targ = (st_reg.fsm == S_RD_TBL || st_reg.gr2 == 32'h0) ? i_mem_rdata : 8'h00;
  // Two digits per step after the sign step; wide divide traded for fewer cycles
  assign q1 = st_reg.mag / 64'd10;
  assign m1 = st_reg.mag % 64'd10;
  assign q2 = q1 / 64'd10;
  assign m2 = q1 % 64'd10;
  assign dg = i_mem_rdata[3:0];
  assign sg = i_mem_rdata[7:4];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.rdata = 32'h0;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        `SDMU_A_CTRL: st_next.rdata[`SDMU_CT_OP] = st_reg.op;
        `SDMU_A_STAT: begin
          st_next.rdata[`SDMU_ST_BUSY] = st_reg.busy;
          st_next.rdata[`SDMU_ST_SUSP] = st_reg.susp;
          st_next.rdata[`SDMU_ST_CC] = st_reg.cc;
        end
        `SDMU_A_GR0: st_next.rdata = st_reg.gr0;
        `SDMU_A_GR1: st_next.rdata = st_reg.gr1;
        `SDMU_A_GR2: st_next.rdata = st_reg.gr2;
        `SDMU_A_ADR1: st_next.rdata = st_reg.a1;
        `SDMU_A_LEN1: st_next.rdata = st_reg.l1;
        `SDMU_A_ADR2: st_next.rdata = st_reg.a2;
        `SDMU_A_LEN2: st_next.rdata = st_reg.l2;
        `SDMU_A_PHI: st_next.rdata = st_reg.hi;
        `SDMU_A_PLO: st_next.rdata = st_reg.lo;
        default: st_next.rdata = 32'h0;
      endcase
    end
    // Writes while busy are dropped so working pointers stay coherent
    if (i_bus.wr && !st_reg.busy) begin
      unique case (i_bus.addr)
        `SDMU_A_CTRL: begin
          if (i_bus.wdata[`SDMU_CT_RES] && st_reg.susp) begin
            st_next.busy = 1'b1;
            st_next.susp = 1'b0;
            st_next.fsm = S_STEP;
          end else if (i_bus.wdata[`SDMU_CT_GO]) begin
            st_next.op = i_bus.wdata[`SDMU_CT_OP];
            st_next.busy = 1'b1;
            st_next.susp = 1'b0;
            st_next.fsm = S_STEP;
            st_next.cnt = 32'h0;
            st_next.half = 1'b0;
            st_next.sgn_done = 1'b0;
            st_next.ovf = 1'b0;
            st_next.bad = 1'b0;
            st_next.neg = st_reg.hi[31];
            st_next.nzero = |{st_reg.hi, st_reg.lo};
            st_next.mag = st_reg.hi[31] ? 64'h0 - {st_reg.hi, st_reg.lo} : {st_reg.hi, st_reg.lo};
            if (i_bus.wdata[2:1] == 2'h3) begin
              // Point at the low-order bytes of both strings
              st_next.l1 = st_reg.l1 + 32'h1; // see RQ17
              st_next.l2 = st_reg.l2 + 32'h1; // see RQ17
              st_next.a1 = st_reg.a1 + st_reg.l1;
              st_next.a2 = st_reg.a2 + st_reg.l2;
              st_next.nzero = 1'b0;
              st_next.neg = 1'b0;
            end
          end
        end
        `SDMU_A_GR0: st_next.gr0 = i_bus.wdata;
        `SDMU_A_GR1: st_next.gr1 = i_bus.wdata;
        `SDMU_A_GR2: st_next.gr2 = i_bus.wdata;
        `SDMU_A_ADR1: st_next.a1 = i_bus.wdata;
        `SDMU_A_LEN1: st_next.l1 = i_bus.wdata;
        `SDMU_A_ADR2: st_next.a2 = i_bus.wdata;
        `SDMU_A_LEN2: st_next.l2 = i_bus.wdata;
        `SDMU_A_PHI: st_next.hi = i_bus.wdata;
        `SDMU_A_PLO: st_next.lo = i_bus.wdata;
        default: st_next.gr1 = st_reg.gr1;
      endcase
    end

    unique case (st_reg.fsm)
      S_IDLE: st_next.mem.req = 1'b0;
      S_STEP: begin
        if (i_intr) begin
          // All progress lives in registers, so resume restarts here
          st_next.busy = 1'b0; // see RQ3
          st_next.susp = 1'b1;
          st_next.fsm = S_IDLE;
        end else begin
          unique case (st_reg.op)
            `SDMU_OP_STORE_BINARY_AS_PACKED: begin
              if (st_reg.cnt == `SDMU_STORE_BINARY_AS_PACKED_BYTES) begin
                st_next = f_fin(st_next, {2'h0, st_reg.nzero & ~st_reg.neg, st_reg.neg}); // see RQ1
              end else begin
                st_next.mag = (st_reg.cnt == 32'h0) ? q1 : q2;
                st_next.cnt = st_reg.cnt + 32'h1;
                st_next = f_iss(st_next, st_reg.a2 + `SDMU_STORE_BINARY_AS_PACKED_LAST - st_reg.cnt, 1'b1,
                  (st_reg.cnt == 32'h0) ? {m1[3:0], st_reg.neg ? `SDMU_SGN_MINUS : `SDMU_SGN_PLUS}
                                        : {m2[3:0], m1[3:0]}, S_WR_DST); // see RQ1
              end
            end
            `SDMU_OP_MOVE_TRANSLATED_UNTIL_ESCAPE: begin
              st_next.gr1 = st_reg.a2; // see RQ8
              if (st_reg.l2 == 32'h0) begin
                st_next = f_fin(st_next, `SDMU_CC_ZERO); // see RQ7
              end else if (st_reg.l1 == 32'h0) begin
                st_next = f_fin(st_next, `SDMU_CC_V); // see RQ7
              end else begin
                st_next = f_iss(st_next, st_reg.a2, 1'b0, 8'h00, S_RD_SRC);
              end
            end
            `SDMU_OP_MOVE, `SDMU_OP_COPY_WITH_SPACE_PAD: begin
              st_next.gr1 = st_reg.a2; // see RQ8
              if (st_reg.l1 == 32'h0) begin
                st_next = f_fin(st_next, (st_reg.l2 != 32'h0) ? `SDMU_CC_V : `SDMU_CC_ZERO); // see RQ11
              end else if (st_reg.l2 == 32'h0) begin
                st_next.from_src = 1'b0;
                st_next = f_iss(st_next, st_reg.a1, 1'b1, pad, S_WR_DST); // see RQ10
              end else begin
                st_next = f_iss(st_next, st_reg.a2, 1'b0, 8'h00, S_RD_SRC);
              end
            end
            `SDMU_OP_TEXT_COMPARE_WITH_PAD, `SDMU_OP_TEXT_COMPARE_SPACE_PAD: begin
              st_next.gr1 = st_reg.cnt;
              if (st_reg.l1 == 32'h0 && st_reg.l2 == 32'h0) begin
                st_next = f_fin(st_next, `SDMU_CC_ZERO); // see RQ13 see RQ16
              end else if (st_reg.l1 != 32'h0) begin
                st_next = f_iss(st_next, st_reg.a1, 1'b0, 8'h00, S_RD_OP1);
              end else begin
                st_next.arg = pad; // see RQ14
                st_next = f_iss(st_next, st_reg.a2, 1'b0, 8'h00, S_RD_OP2);
              end
            end
            default: begin
              if (!st_reg.sgn_done) begin
                st_next = f_iss(st_next, st_reg.a2, 1'b0, 8'h00, S_PK_RD); // see RQ22
              end else if (st_reg.l1 == 32'h0 && st_reg.half) begin
                st_next.half = 1'b0;
                st_next.ovf = st_reg.ovf | (st_reg.nib != 4'h0); // see RQ20
              end else if (st_reg.l1 == 32'h0 && st_reg.l2 == 32'h0) begin
                st_next = f_fin(st_next, {st_reg.bad, st_reg.ovf,
                  st_reg.nzero & ~(st_reg.neg & st_reg.op == `SDMU_OP_PMV),
                  st_reg.nzero & st_reg.neg & st_reg.op == `SDMU_OP_PMV}); // see RQ18 see RQ21
              end else if (st_reg.l2 != 32'h0) begin
                st_next = f_iss(st_next, st_reg.a2, 1'b0, 8'h00, S_PK_RD);
              end else begin
                // Source ran out: zero digits fill the high end
                st_next.half = 1'b0;
                st_next = f_iss(st_next, st_reg.a1, 1'b1, {4'h0, st_reg.half ? st_reg.nib : 4'h0},
                  S_WR_DST); // see RQ18
              end
            end
          endcase
        end
      end
      S_RD_SRC, S_RD_TBL: begin
        if (ak) begin
          st_next.mem.req = 1'b0;
          st_next.from_src = 1'b1;
          if (st_reg.op == `SDMU_OP_MOVE_TRANSLATED_UNTIL_ESCAPE && st_reg.fsm == S_RD_SRC && st_reg.gr2 != 32'h0) begin
            st_next = f_iss(st_next, st_reg.gr2 + {24'h0, i_mem_rdata}, 1'b0, 8'h00, S_RD_TBL); // see RQ5
          end else if (st_reg.op == `SDMU_OP_MOVE_TRANSLATED_UNTIL_ESCAPE && targ == st_reg.gr0[7:0]) begin
            st_next = f_fin(st_next, `SDMU_CC_C); // see RQ4 see RQ6
          end else begin
            st_next = f_iss(st_next, st_reg.a1, 1'b1, (st_reg.op == `SDMU_OP_MOVE_TRANSLATED_UNTIL_ESCAPE) ? targ : i_mem_rdata,
              S_WR_DST); // see RQ6
          end
        end
      end
      S_WR_DST: begin
        if (ak) begin
          st_next.mem.req = 1'b0;
          st_next.fsm = S_STEP;
          if (is_pk) begin
            st_next.a1 = st_reg.a1 - 32'h1; // see RQ22
            st_next.l1 = st_reg.l1 - 32'h1;
          end else if (st_reg.op != `SDMU_OP_STORE_BINARY_AS_PACKED) begin
            // Ascending order; a source left of the destination is not guarded
            st_next.a1 = st_reg.a1 + 32'h1; // see RQ9
            st_next.l1 = st_reg.l1 - 32'h1;
            if (st_reg.from_src) begin
              st_next.a2 = st_reg.a2 + 32'h1;
              st_next.l2 = st_reg.l2 - 32'h1;
            end
          end
        end
      end
      S_RD_OP1: begin
        if (ak) begin
          st_next.mem.req = 1'b0;
          st_next.arg = i_mem_rdata;
          if (st_reg.l2 != 32'h0) begin
            st_next = f_iss(st_next, st_reg.a2, 1'b0, 8'h00, S_RD_OP2);
          end else begin
            st_next.cmpb = pad; // see RQ14
            st_next.fsm = S_CP_CMP;
          end
        end
      end
      S_RD_OP2: begin
        if (ak) begin
          st_next.mem.req = 1'b0;
          st_next.cmpb = i_mem_rdata;
          st_next.fsm = S_CP_CMP;
        end
      end
      S_CP_CMP: begin
        if (st_reg.arg != st_reg.cmpb) begin
          st_next.gr1 = st_reg.cnt; // see RQ15
          st_next = f_fin(st_next, (st_reg.arg > st_reg.cmpb) ? `SDMU_CC_GT : `SDMU_CC_LT); // see RQ16
        end else begin
          st_next.fsm = S_STEP;
          if (st_reg.l1 != 32'h0) begin
            st_next.a1 = st_reg.a1 + 32'h1;
            st_next.l1 = st_reg.l1 - 32'h1;
          end
          if (st_reg.l2 != 32'h0) begin
            st_next.cnt = st_reg.cnt + 32'h1; // see RQ15
            st_next.a2 = st_reg.a2 + 32'h1;
            st_next.l2 = st_reg.l2 - 32'h1;
          end
        end
      end
      S_PK_RD: begin
        if (ak) begin
          st_next.mem.req = 1'b0;
          st_next.fsm = S_STEP;
          st_next.a2 = st_reg.a2 - 32'h1;
          st_next.l2 = st_reg.l2 - 32'h1;
          st_next.nzero = st_reg.nzero | (dg != 4'h0);
          st_next.bad = st_reg.bad | (dg > 4'h9); // see RQ21 see RQ23
          if (!st_reg.sgn_done) begin
            st_next.sgn_done = 1'b1;
            st_next.neg = f_minus(sg); // see RQ23
            st_next.bad = st_reg.bad | (dg > 4'h9) | ~f_sgn_ok(sg); // see RQ21 see RQ23
            st_next = f_iss(st_next, st_reg.a1, 1'b1, {dg, (st_reg.op == `SDMU_OP_ZONED_TO_PACKED_COPY_POSITIVE || !f_minus(sg)) ?
              `SDMU_SGN_PLUS : `SDMU_SGN_MINUS}, S_WR_DST); // see RQ19
          end else if (st_reg.l1 == 32'h0) begin
            st_next.ovf = st_reg.ovf | (dg != 4'h0); // see RQ20
          end else if (!st_reg.half) begin
            st_next.nib = dg;
            st_next.half = 1'b1;
          end else begin
            st_next.half = 1'b0;
            st_next = f_iss(st_next, st_reg.a1, 1'b1, {dg, st_reg.nib}, S_WR_DST); // see RQ18
          end
        end
      end
      default: st_next.fsm = S_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_mem = st_reg.mem;
  assign o_busy = st_reg.busy;
  assign o_susp = st_reg.susp;
  assign o_done = st_reg.done;
  assign o_cc = st_reg.cc;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_ack;
    i_ce && o_mem.req && i_mem_ack;
  endsequence
  sequence s_wait;
    i_ce && o_mem.req && !i_mem_ack;
  endsequence

  a_req_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see RQ9
    s_wait |=> o_mem.req && $stable(o_mem.addr)) else $error("request dropped before ack");
  a_tbl_index: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see RQ5
    s_ack ##0 (st_reg.fsm == S_RD_SRC && st_reg.op == `SDMU_OP_MOVE_TRANSLATED_UNTIL_ESCAPE && st_reg.gr2 != 32'h0)
    |=> st_reg.fsm == S_RD_TBL && o_mem.addr == $past(st_reg.gr2) + {24'h0, $past(i_mem_rdata)})
    else $error("table address wrong");
  a_escape_stop: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see RQ6
    s_ack ##0 (st_reg.fsm == S_RD_SRC && st_reg.op == `SDMU_OP_MOVE_TRANSLATED_UNTIL_ESCAPE && st_reg.gr2 == 32'h0
    && i_mem_rdata == st_reg.gr0[7:0]) |=> o_cc == `SDMU_CC_C && !o_busy && !o_mem.req)
    else $error("escape not honoured");
  a_move_ovf: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see RQ11
    (i_ce && !i_intr && st_reg.fsm == S_STEP && st_reg.op[2:1] == 2'h1 && st_reg.l1 == 32'h0
    && st_reg.l2 != 32'h0) |=> o_cc == `SDMU_CC_V && o_done) else $error("move overflow code");
  a_pad_byte: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see RQ10
    (st_reg.fsm == S_WR_DST && st_reg.op == `SDMU_OP_COPY_WITH_SPACE_PAD && !st_reg.from_src && o_mem.req)
    |-> o_mem.wdata == `SDMU_PAD_SPACE) else $error("default pad not space");
  a_cmp_count: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see RQ15
    (i_ce && st_reg.fsm == S_CP_CMP && st_reg.arg != st_reg.cmpb)
    |=> st_reg.gr1 == $past(st_reg.cnt) && o_done ##1 !o_done) else $error("compare count wrong");
  a_intr_stop: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see RQ3
    (i_ce && i_intr && st_reg.fsm == S_STEP) |=> o_susp && !o_busy) else $error("interrupt ignored");
  a_gr1_next: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see RQ8
    (o_done && st_reg.op[2:1] == 2'h1 && o_cc != `SDMU_CC_C) |-> st_reg.gr1 == st_reg.a2)
    else $error("register 1 not next source");
  a_pk_sign: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see RQ19
    (st_reg.fsm == S_WR_DST && st_reg.op == `SDMU_OP_ZONED_TO_PACKED_COPY_POSITIVE && o_mem.req && st_reg.cnt == 32'h0
    && st_reg.l1 == $past(st_reg.l1) && $past(st_reg.fsm) == S_PK_RD && !$past(st_reg.sgn_done))
    |-> o_mem.wdata[3:0] == `SDMU_SGN_PLUS) else $error("absolute sign not plus");
endmodule : sdmu_unit

// ### tb/sdmu_mem_model.sv
// Byte memory partner of the string unit: one ack pulse per request.
// Assumes one outstanding request, held by the unit until its ack.
`timescale 1ns/1ns
module sdmu_mem_model
  import sdmu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire sdmu_mreq_s i_mem,
  input wire logic [3:0] i_delay,
  output logic o_ack,
  output logic [7:0] o_rdata
);
  logic [7:0] bytes [0:255];
  logic [3:0] wait_reg;
  logic [7:0] last_reg;
  logic hit_reg;
  // ----------------------------
  // Answer
  // ----------------------------
  // Ack is gated by its own last value, so it never repeats on a request still held at the ack edge
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      hit_reg <= 1'b0;
      wait_reg <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      hit_reg <= 1'b0;
      if (i_mem.req && !o_ack) begin
        wait_reg <= wait_reg + 4'h1;
        if (wait_reg >= i_delay) begin
          o_ack <= 1'b1;
          wait_reg <= 4'h0;
          hit_reg <= !i_mem.we;
          last_reg <= bytes[i_mem.addr[7:0]];
          if (i_mem.we) bytes[i_mem.addr[7:0]] <= i_mem.wdata;
        end
      end
    end
  end
  // Released bus shows the inverse, never a stale byte
  assign o_rdata = hit_reg ? last_reg : ~last_reg;
endmodule : sdmu_mem_model

// ### tb/string_decimal_move_unit_tb_top.sv
// Self-checking bench of the string and decimal move unit.
// Assumes the package, the unit and the byte memory model are compiled first.
`timescale 1ns/1ns
`include "sdmu_regs.svh"
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("mismatch %0t %s", $time, m); end end
module string_decimal_move_unit_tb_top
  import sdmu_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic intr = 1'b0;
  logic [3:0] delay = 4'h0;
  sdmu_bus_s bus = '0;
  sdmu_mreq_s mreq;
  logic [31:0] rdata;
  logic ack;
  logic [7:0] mrd;
  logic busy;
  logic susp;
  logic done;
  logic [3:0] cc;
  int n_errors = 0;
  int total_checks = 0;

  sdmu_unit uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(1'b1), .i_bus(bus), .o_rdata(rdata),
    .i_intr(intr), .o_mem(mreq), .i_mem_ack(ack), .i_mem_rdata(mrd), .o_busy(busy), .o_susp(susp),
    .o_done(done), .o_cc(cc));
  sdmu_mem_model mem (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mem(mreq), .i_delay(delay),
    .o_ack(ack), .o_rdata(mrd));

  initial forever #4 i_clk_sys = ~i_clk_sys;

  // ----------------------------
  // Bus and memory helpers
  // ----------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge i_clk_sys);
    bus <= '0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic xr(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk_sys);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge i_clk_sys);
    bus <= '0;
    #1;
    `CHK(rdata, e, "reg")
    @(posedge i_clk_sys);
    #1;
    `CHK(rdata, 32'h0, "read data held")
  endtask : xr

  task automatic put(input logic [7:0] a, input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) mem.bytes[a + i] = v[8 * (n - 1 - i) +: 8];
  endtask : put

  task automatic xb(input logic [7:0] a, input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) `CHK(mem.bytes[a + i], v[8 * (n - 1 - i) +: 8], "byte")
  endtask : xb

  task automatic go(input logic [2:0] op, input logic [31:0] a1, l1, a2, l2);
    wr(`SDMU_A_ADR1, a1);
    wr(`SDMU_A_LEN1, l1);
    wr(`SDMU_A_ADR2, a2);
    wr(`SDMU_A_LEN2, l2);
    wr(`SDMU_A_CTRL, {28'h1, 1'b0, op});
  endtask : go

  task automatic fin();
    for (int k = 0; k < 3000 && done !== 1'b1; k++) begin
      @(posedge i_clk_sys);
      #1;
    end
    `CHK(done, 1'b1, "done")
  endtask : fin

  task automatic run(input logic [2:0] op, input logic [31:0] a1, l1, a2, l2);
    go(op, a1, l1, a2, l2);
    fin();
  endtask : run

  // ----------------------------
  // Scenarios
  // ----------------------------
  task automatic t_move();
    put(8'h10, 64'h6162, 2);
    put(8'h28, 64'h5555, 2);
    wr(`SDMU_A_GR0, 32'hffff_ff2a);
    run(3'h2, 32'h20, 32'h4, 32'h10, 32'h2);
    `CHK(cc, `SDMU_CC_ZERO, "cc")
    xb(8'h20, 64'h6162_2a2a, 4);
    xr(`SDMU_A_GR1, 32'h12);
    run(3'h2, 32'h28, 32'h1, 32'h10, 32'h2);
    `CHK(cc, `SDMU_CC_V, "cc")
    xb(8'h28, 64'h6155, 2);
    xr(`SDMU_A_GR1, 32'h11);
    run(3'h3, 32'h30, 32'h3, 32'h10, 32'h1);
    xb(8'h30, 64'h612020, 3);
  endtask : t_move

  task automatic t_intr();
    wr(`SDMU_A_GR0, 32'h2a);
    delay <= 4'h3;
    go(3'h2, 32'h90, 32'h8, 32'h10, 32'h2);
    repeat (8) @(posedge i_clk_sys);
    intr <= 1'b1;
    for (int k = 0; k < 100 && susp !== 1'b1; k++) begin
      @(posedge i_clk_sys);
      #1;
    end
    repeat (20) @(posedge i_clk_sys);
    intr <= 1'b0;
    #1;
    `CHK({susp, busy, done}, 3'b100, "held")
    wr(`SDMU_A_CTRL, {27'h1, 2'h0, 3'h2});
    fin();
    xb(8'h90, 64'h6162_2a2a_2a2a_2a2a, 8);
    delay <= 4'h0;
  endtask : t_intr

  task automatic t_move_translated_until_escape();
    put(8'h40, 64'h010203, 3);
    put(8'hc1, 64'h61627e, 3);
    put(8'h48, 64'h5555_5555, 4);
    wr(`SDMU_A_GR0, 32'hab00_007e);
    wr(`SDMU_A_GR2, 32'hc0);
    run(3'h1, 32'h48, 32'h3, 32'h40, 32'h3);
    `CHK(cc, `SDMU_CC_C, "cc")
    xb(8'h48, 64'h616255, 3);
    xr(`SDMU_A_GR1, 32'h42);
    wr(`SDMU_A_GR2, 32'h0);
    run(3'h1, 32'h48, 32'h2, 32'h40, 32'h3);
    `CHK(cc, `SDMU_CC_V, "cc")
    run(3'h1, 32'h48, 32'h4, 32'h40, 32'h3);
    `CHK(cc, `SDMU_CC_ZERO, "cc")
    xb(8'h48, 64'h0102_0355, 4);
    xr(`SDMU_A_GR1, 32'h43);
  endtask : t_move_translated_until_escape

  task automatic t_cmp();
    put(8'h50, 64'h414243, 3);
    put(8'h58, 64'h4142_4344_4444, 6);
    wr(`SDMU_A_GR0, 32'h44);
    run(3'h5, 32'h50, 32'h3, 32'h58, 32'h6);
    `CHK(cc, `SDMU_CC_LT, "cc")
    xr(`SDMU_A_GR1, 32'h3);
    run(3'h4, 32'h50, 32'h3, 32'h58, 32'h6);
    `CHK(cc, `SDMU_CC_ZERO, "cc")
    xr(`SDMU_A_GR1, 32'h6);
    run(3'h5, 32'h58, 32'h6, 32'h50, 32'h3);
    `CHK(cc, `SDMU_CC_GT, "cc")
    xr(`SDMU_A_GR1, 32'h3);
  endtask : t_cmp

  task automatic t_pack();
    put(8'h60, 64'h3132d3, 3);
    put(8'h64, 64'h3ac1, 2);
    put(8'h78, 64'h3030f5, 3);
    run(3'h6, 32'h68, 32'h1, 32'h60, 32'h2);
    `CHK(cc, `SDMU_CC_LT, "cc")
    xb(8'h68, 64'h123d, 2);
    run(3'h7, 32'h68, 32'h1, 32'h60, 32'h2);
    `CHK(cc, `SDMU_CC_GT, "cc")
    xb(8'h68, 64'h123c, 2);
    run(3'h6, 32'h6c, 32'h2, 32'h60, 32'h2);
    xb(8'h6c, 64'h00123d, 3);
    run(3'h6, 32'h70, 32'h0, 32'h60, 32'h2);
    `CHK(cc, 4'h5, "cc")
    xb(8'h70, 64'h3d, 1);
    run(3'h6, 32'h7c, 32'h0, 32'h78, 32'h2);
    `CHK(cc, `SDMU_CC_GT, "cc")
    xb(8'h7c, 64'h5c, 1);
    run(3'h6, 32'h74, 32'h1, 32'h64, 32'h1);
    `CHK(cc[3], 1'b1, "cc")
  endtask : t_pack

  task automatic t_store_binary_as_packed();
    wr(`SDMU_A_PHI, 32'hffff_ffff);
    wr(`SDMU_A_PLO, 32'hffff_ff85);
    go(3'h0, 32'h0, 32'h0, 32'ha0, 32'h0);
    xr(`SDMU_A_STAT, 32'ha1);
    fin();
    `CHK(cc, `SDMU_CC_LT, "cc")
    xb(8'ha0, 64'h0, 8);
    xb(8'ha8, 64'h123d, 8);
  endtask : t_store_binary_as_packed

  task automatic complete_run();
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    xr(`SDMU_A_STAT, 32'h0);
    xr(8'h30, 32'h0);
    t_move();
    t_intr();
    t_move_translated_until_escape();
    t_cmp();
    t_pack();
    t_store_binary_as_packed();
    complete_run();
  end

  // About 17 operations of at most a few hundred cycles each
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_errors++;
    complete_run();
  end
endmodule : string_decimal_move_unit_tb_top
